// ===== design/pmux_top.sv
// pin output source multiplexer with its apb register file
// assumes status inputs are asynchronous levels from other blocks
//
// Functional notes
// - source codes pick rx0-3, status, transmit
// - rx source: select 0-3 gives remote pins
// - rx source: lock, pass, frame, line valid
// - status select 000 drives stored value
// - status group: or/and lock, and pass, sync
// - transmit: and pass, or pass, frame valid
// - transmit: line valid, synchronized, interrupt
// - stored value bit writable and driven out
// - control register resets to zero, driver off
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "pmux_consts.svh"
module pmux_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PMUX_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // receive port status, port p owns bits p*4+3..p*4 of the pins
  input wire logic [15:0] rx_remote_pin,
  input wire logic [3:0] rx_lock,
  input wire logic [3:0] rx_pass,
  input wire logic [3:0] rx_frame_valid,
  input wire logic [3:0] rx_line_valid,
  // device and transmit port status
  input wire logic frame_sync_pulse,
  input wire logic tx_frame_valid,
  input wire logic tx_line_valid,
  input wire logic tx_synchronized,
  input wire logic tx_interrupt,
  // general pin five, output side of the pad
  output logic general_pin_five_o,
  output logic general_pin_five_oe_n
);

  // ---------------------------------------------------------------
  // synchronised copies of every status input
  // ---------------------------------------------------------------
  logic [`PMUX_SYNC_W-1:0] sync_q; // all status, two flops deep
  logic [15:0] pin_s; // remote pins
  logic [3:0] lock_s; // lock per port
  logic [3:0] pass_s; // pass per port
  logic [3:0] fv_s; // frame valid per port
  logic [3:0] lv_s; // line valid per port
  logic fsync_s; // frame sync pulse
  logic [3:0] tx_s; // {int, synchronized, line, frame}

  // one synchroniser keeps the path depth equal for every source
  pmux_sync #(
    .W(`PMUX_SYNC_W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({tx_interrupt, tx_synchronized, tx_line_valid, tx_frame_valid,
        frame_sync_pulse, rx_line_valid, rx_frame_valid, rx_pass,
        rx_lock, rx_remote_pin}),
    .q(sync_q)
  );

  assign pin_s = sync_q[15:0];
  assign lock_s = sync_q[19:16];
  assign pass_s = sync_q[23:20];
  assign fv_s = sync_q[27:24];
  assign lv_s = sync_q[31:28];
  assign fsync_s = sync_q[32];
  assign tx_s = sync_q[36:33];

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [7:0] ctrl_reg; // pin_output_control
  logic [7:0] ctrl_next;
  logic [3:0] mask_reg; // receive ports taking part in and/or
  logic [3:0] mask_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pin_reg; // pad output level
  logic pin_next;
  logic oe_n_reg; // pad enable, low while driving
  logic oe_n_next;

  // fields of the control register
  pmux_pkg::pmux_sel_t sel; // pin_signal_select
  logic [2:0] src; // pin_source_select
  logic stored; // pin_stored_value
  logic drv_en; // pin_driver_enable

  assign sel = ctrl_reg[`PMUX_SEL_MSB:`PMUX_SEL_LSB];
  assign src = ctrl_reg[`PMUX_SRC_MSB:`PMUX_SRC_LSB];
  assign stored = ctrl_reg[`PMUX_VAL_BIT];
  assign drv_en = ctrl_reg[`PMUX_EN_BIT];

  // ---------------------------------------------------------------
  // group selectors
  // ---------------------------------------------------------------
  logic [1:0] port; // receive port chosen by the source
  logic or_lock; // any enabled port locked
  logic and_lock; // all enabled ports locked
  logic and_pass; // all enabled ports pass
  logic or_pass; // any enabled port passes
  logic rx_y; // receive group pick
  logic st_y; // device status group pick
  logic tx_y; // transmit group pick
  logic level; // chosen level before the driver gate

  assign port = src[1:0];
  // an empty port mask yields low for the and terms too
  assign or_lock = |(lock_s & mask_reg);
  assign and_lock = (mask_reg != 4'h0) & (&(lock_s | ~mask_reg));
  assign and_pass = (mask_reg != 4'h0) & (&(pass_s | ~mask_reg));
  assign or_pass = |(pass_s & mask_reg);

  // receive port: four remote pins, then lock, pass, frame, line
  pmux_mux8 u_rx_mux (
    .d({lv_s[port], fv_s[port], pass_s[port], lock_s[port],
        pin_s[{port, 2'b00} +: 4]}),
    .legal(`PMUX_RX_LEGAL),
    .sel(sel),
    .y(rx_y)
  );

  // device status: stored value first, codes 101-111 reserved
  pmux_mux8 u_st_mux (
    .d({3'b000, fsync_s, and_pass, and_lock, or_lock, stored}),
    .legal(`PMUX_ST_LEGAL),
    .sel(sel),
    .y(st_y)
  );

  // transmit port: 110 and 111 are unassigned and treated as reserved
  pmux_mux8 u_tx_mux (
    .d({2'b00, tx_s[3], tx_s[2], tx_s[1], tx_s[0], or_pass,
        and_pass}),
    .legal(`PMUX_TX_LEGAL),
    .sel(sel),
    .y(tx_y)
  );

  // source decode; the reserved sources fall to low
  always_comb begin
    case (src)
      pmux_pkg::PMUX_SRC_RX0,
      pmux_pkg::PMUX_SRC_RX1,
      pmux_pkg::PMUX_SRC_RX2,
      pmux_pkg::PMUX_SRC_RX3: level = rx_y;
      pmux_pkg::PMUX_SRC_STATUS: level = st_y;
      pmux_pkg::PMUX_SRC_TX: level = tx_y;
      default: level = 1'b0;
    endcase
  end

  // pad next values: disabled driver floats and outputs low
  always_comb begin
    pin_next = drv_en & level;
    oe_n_next = ~drv_en;
  end

  // pad registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_reg <= 1'b0;
      oe_n_reg <= 1'b1;
    end else begin
      pin_reg <= pin_next;
      oe_n_reg <= oe_n_next;
    end
  end

  // ---------------------------------------------------------------
  // apb slave: one wait state, answer registered with pready
  // ---------------------------------------------------------------
  logic acc_go; // access cycle, answer not yet given
  logic acc_done; // edge where the transfer completes
  logic hit_ctrl;
  logic hit_mask;
  logic hit_stat;

  assign acc_go = psel & penable & ~pready_reg;
  assign acc_done = psel & penable & pready_reg;
  assign hit_ctrl = (paddr == `PMUX_CTRL_ADDR);
  assign hit_mask = (paddr == `PMUX_MASK_ADDR);
  assign hit_stat = (paddr == `PMUX_STAT_ADDR);

  // next values of the bus answer and of writable registers
  always_comb begin
    pready_next = acc_go;
    pslverr_next = acc_go & ~(hit_ctrl | hit_mask | hit_stat);
    prdata_next = prdata_reg;
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    if (acc_go) begin
      // read data is captured once, together with pready
      if (pwrite | pslverr_next) begin
        prdata_next = 32'h0000_0000;
      end else if (hit_ctrl) begin
        prdata_next = {24'h00_0000, ctrl_reg};
      end else if (hit_mask) begin
        prdata_next = {28'h000_0000, mask_reg};
      end else begin
        prdata_next = {24'h00_0000, tx_s[0], fsync_s, lock_s,
                       pin_reg, ~oe_n_reg};
      end
    end
    // writes land only at the completing edge, low lane only
    if (acc_done & pwrite & pstrb[0]) begin
      if (hit_ctrl) begin
        ctrl_next = pwdata[7:0];
      end else if (hit_mask) begin
        mask_next = pwdata[3:0];
      end
    end
  end

  // bus registers; control clears to zero, all ports in the mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `PMUX_CTRL_RESET;
      mask_reg <= `PMUX_MASK_RESET;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign general_pin_five_o = pin_reg;
  assign general_pin_five_oe_n = oe_n_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic rx_src;
  assign rx_src = ~src[2];

  // reserved sources give a low pin one edge later
  property p_src_reserved;
    @(posedge pclk) disable iff (!presetn)
    drv_en && (src == 3'h5 || src == 3'h7) |=> !general_pin_five_o;
  endproperty
  a_src_reserved: assert property (p_src_reserved)
    else $error("reserved source did not drive low");

  // remote pins follow the chosen port and pin number
  property p_rx_pin;
    @(posedge pclk) disable iff (!presetn)
    drv_en && rx_src && !sel[2]
      |=> general_pin_five_o == $past(pin_s[{src[1:0], sel[1:0]}]);
  endproperty
  a_rx_pin: assert property (p_rx_pin)
    else $error("remote pin not forwarded");

  // lock of the chosen port
  property p_rx_lock;
    @(posedge pclk) disable iff (!presetn)
    drv_en && rx_src && sel == 3'h4
      |=> general_pin_five_o == $past(lock_s[src[1:0]]);
  endproperty
  a_rx_lock: assert property (p_rx_lock)
    else $error("port lock not forwarded");

  // line valid of the chosen port
  property p_rx_line;
    @(posedge pclk) disable iff (!presetn)
    drv_en && rx_src && sel == 3'h7
      |=> general_pin_five_o == $past(lv_s[src[1:0]]);
  endproperty
  a_rx_line: assert property (p_rx_line)
    else $error("port line valid not forwarded");

  // stored value reaches the pin
  property p_stored;
    @(posedge pclk) disable iff (!presetn)
    drv_en && src == 3'h4 && sel == 3'h0
      |=> general_pin_five_o == $past(ctrl_reg[1]);
  endproperty
  a_stored: assert property (p_stored)
    else $error("stored value not driven");

  // or of lock over enabled ports
  property p_or_lock;
    @(posedge pclk) disable iff (!presetn)
    drv_en && src == 3'h4 && sel == 3'h1
      |=> general_pin_five_o == $past(|(lock_s & mask_reg));
  endproperty
  a_or_lock: assert property (p_or_lock)
    else $error("or of lock wrong");

  // and of pass on the transmit group
  property p_tx_and;
    @(posedge pclk) disable iff (!presetn)
    drv_en && src == 3'h6 && sel == 3'h0
      |=> general_pin_five_o
        == $past(mask_reg != 4'h0 && (pass_s | ~mask_reg) == 4'hF);
  endproperty
  a_tx_and: assert property (p_tx_and)
    else $error("and of pass wrong");

  // transmit interrupt
  property p_tx_int;
    @(posedge pclk) disable iff (!presetn)
    drv_en && src == 3'h6 && sel == 3'h5
      |=> general_pin_five_o == $past(tx_s[3]);
  endproperty
  a_tx_int: assert property (p_tx_int)
    else $error("transmit interrupt not forwarded");

  // a completed control write shows on the pad two edges later
  sequence s_ctrl_write;
    psel && penable && pready && pwrite && pstrb[0]
      && paddr == `PMUX_CTRL_ADDR;
  endsequence
  property p_write_drive;
    @(posedge pclk) disable iff (!presetn)
    s_ctrl_write ##1 1'b1
      |=> general_pin_five_oe_n == !$past(pwdata[0], 2);
  endproperty
  a_write_drive: assert property (p_write_drive)
    else $error("driver enable did not follow write");

  // disabled driver never drives and never shows a high level
  property p_disabled;
    @(posedge pclk) disable iff (!presetn)
    !drv_en |=> general_pin_five_oe_n && !general_pin_five_o;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("pad driven while disabled");

  // reserved status selects stay low
  property p_sel_reserved;
    @(posedge pclk) disable iff (!presetn)
    drv_en && src == 3'h4 && sel > 3'h4 |=> !general_pin_five_o;
  endproperty
  a_sel_reserved: assert property (p_sel_reserved)
    else $error("reserved select did not drive low");

  // access phase answers after exactly one wait state
  sequence s_access_start;
    psel && penable && !pready;
  endsequence
  property p_apb_wait;
    @(posedge pclk) disable iff (!presetn)
    s_access_start |=> pready ##1 !pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("apb answer timing wrong");

endmodule

// ===== design/pmux_consts.svh
// register map, field positions, reset values and select codes
// of the pin output source multiplexer; included by its bare name
`ifndef PMUX_CONSTS_SVH
`define PMUX_CONSTS_SVH

// apb address width, control word index and register byte addresses
`define PMUX_AW 12
`define PMUX_CTRL_INDEX 8'h15
`define PMUX_CTRL_ADDR 12'h054
`define PMUX_MASK_ADDR 12'h080
`define PMUX_STAT_ADDR 12'h084

// reset values
`define PMUX_CTRL_RESET 8'h00
`define PMUX_MASK_RESET 4'hF

// pin_output_control fields
`define PMUX_SEL_MSB 7
`define PMUX_SEL_LSB 5
`define PMUX_SRC_MSB 4
`define PMUX_SRC_LSB 2
`define PMUX_VAL_BIT 1
`define PMUX_EN_BIT 0

// legal select codes per group, one bit per code
`define PMUX_RX_LEGAL 8'hFF
`define PMUX_ST_LEGAL 8'h1F
`define PMUX_TX_LEGAL 8'h3F

// width of the synchronised status vector
`define PMUX_SYNC_W 37

`endif

// ===== design/pmux_pkg.sv
// types shared by the pin output source multiplexer
// assumes nothing beyond a systemverilog compiler
package pmux_pkg;

  // source field codes; 101 and 111 are reserved
  typedef enum logic [2:0] {
    PMUX_SRC_RX0 = 3'h0,
    PMUX_SRC_RX1 = 3'h1,
    PMUX_SRC_RX2 = 3'h2,
    PMUX_SRC_RX3 = 3'h3,
    PMUX_SRC_STATUS = 3'h4,
    PMUX_SRC_TX = 3'h6
  } pmux_src_t;

  // signal select code within a group
  typedef logic [2:0] pmux_sel_t;

endpackage

// ===== design/pmux_sync.sv
// two flip-flop synchroniser for a vector of independent levels
// assumes each bit is a slow level; no bus coherence is promised
`timescale 1ns/1ps
module pmux_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg; // first stage, read only by the second
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  // next values: plain shift
  always_comb begin
    meta_next = d;
    q_next = meta_reg;
  end

  // registers clear to zero so the pin stays quiet after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;

endmodule

// ===== design/pmux_mux8.sv
// eight way single bit selector with a per-code legal mask
// assumes sel is already registered or stable within the cycle
`timescale 1ns/1ps
module pmux_mux8 (
  // candidate signals, one per select code
  input wire logic [7:0] d,
  // codes that may be driven; others give low
  input wire logic [7:0] legal,
  // select code
  input wire logic [2:0] sel,
  // chosen level
  output logic y
);

  // reserved codes read low so the pin level stays defined
  assign y = d[sel] & legal[sel];

endmodule

// ===== verification/pmux_board.sv
// board logic on the general pin five net, with a pull-down
// assumes the pad enable is active low, low while driving
`timescale 1ns/1ps
module pmux_board (
  // pad output side of the device
  input wire logic pin_o,
  input wire logic pin_oe_n,
  // level that the board logic sees on the net
  output logic net_level
);
  // a released net falls to the pull-down, never to the last value
  assign net_level = pin_oe_n ? 1'b0 : pin_o;
endmodule

// ===== verification/pin_output_source_mux_tb.sv
// self-checking bench of the pin output source multiplexer
// assumes the apb slave answers with pready and the pad is registered
`timescale 1ns/1ps
`include "pmux_consts.svh"
module pin_output_source_mux_tb;
  // clock, reset and apb master side
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`PMUX_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // status bundle: pins, lock, pass, frame, line, sync, tx four
  logic [36:0] stim = '0;
  // pad and board net
  logic pin_o;
  logic oe_n;
  logic net_level;
  // bookkeeping
  int n_errors = 0;
  int tests_run = 0;
  logic [31:0] rd;
  logic er;

  // 40 mhz clock
  always #12.5 pclk = ~pclk;

  pmux_top i_pmux_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_remote_pin(stim[36:21]), .rx_lock(stim[20:17]),
    .rx_pass(stim[16:13]), .rx_frame_valid(stim[12:9]),
    .rx_line_valid(stim[8:5]), .frame_sync_pulse(stim[4]),
    .tx_frame_valid(stim[3]), .tx_line_valid(stim[2]),
    .tx_synchronized(stim[1]), .tx_interrupt(stim[0]),
    .general_pin_five_o(pin_o), .general_pin_five_oe_n(oe_n)
  );

  pmux_board i_pmux_board (
    .pin_o(pin_o), .pin_oe_n(oe_n), .net_level(net_level)
  );

  // verdict and end of run
  task automatic wrap_up();
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one comparison
  task automatic check(logic [31:0] seen, logic [31:0] exp, string msg);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  // one apb transfer; waits for pready under a bound
  task automatic apb(logic w, logic [`PMUX_AW-1:0] a, logic [31:0] d,
                     logic [3:0] s);
    bit done;
    done = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    for (int i = 0; i < 20 && !done; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        done = 1;
      end
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (!done) begin
      n_errors++;
      wrap_up();
    end
  endtask

  // expected pad level from control, mask and status bundle
  function automatic logic exp_pin(logic [7:0] c, logic [3:0] m,
                                   logic [36:0] s);
    logic [2:0] src;
    logic [15:0] rp;
    logic [3:0] lk, ps, fv, lv;
    logic [7:0] g;
    logic al, ap, op;
    src = c[4:2];
    {rp, lk, ps, fv, lv} = s[36:5];
    al = (m != 4'h0) && ((lk | ~m) == 4'hF);
    ap = (m != 4'h0) && ((ps | ~m) == 4'hF);
    op = |(ps & m);
    g = 8'h00;
    if (!src[2]) begin
      g = {lv[src[1:0]], fv[src[1:0]], ps[src[1:0]], lk[src[1:0]],
           rp[{src[1:0], 2'b00} +: 4]};
    end else if (src == 3'h4) begin
      g = {3'b000, s[4], ap, al, |(lk & m), c[1]};
    end else if (src == 3'h6) begin
      g = {2'b00, s[0], s[1], s[2], s[3], op, ap};
    end
    exp_pin = c[0] & g[c[7:5]];
  endfunction

  // reset values, read-write access, strobe and unmapped address
  task automatic t_regs();
    check(oe_n, 1'b1, "driver on after reset");
    check(pin_o, 1'b0, "pad high after reset");
    apb(0, `PMUX_CTRL_ADDR, 0, 4'hF);
    check(rd, 32'h0000_0000, "control reset");
    apb(0, `PMUX_MASK_ADDR, 0, 4'hF);
    check(rd, 32'h0000_000F, "mask reset");
    apb(1, `PMUX_CTRL_ADDR, 32'h0000_00FF, 4'hF);
    apb(1, `PMUX_CTRL_ADDR, 32'h0000_0000, 4'h0);
    apb(0, `PMUX_CTRL_ADDR, 0, 4'hF);
    check(rd, 32'h0000_00FF, "control write or strobe");
    repeat (3) @(posedge pclk);
    check({oe_n, pin_o}, 2'b00, "reserved source not low");
    apb(0, 12'h088, 0, 4'hF);
    check(er, 1'b1, "unmapped address not flagged");
    check(rd, 32'h0000_0000, "unmapped address read data");
  endtask

  // every source and select code against several bundles and masks
  task automatic t_sweep();
    logic [36:0] pats [3];
    logic [3:0] masks [3];
    logic [7:0] c;
    pats = '{37'h05_A5C3_6E5B, 37'h1A_5A3C_91A4, 37'h1F_FFFF_FFFF};
    masks = '{4'hF, 4'h5, 4'h0};
    foreach (masks[mi]) begin
      apb(1, `PMUX_MASK_ADDR, {28'h0, masks[mi]}, 4'hF);
      foreach (pats[pi]) begin
        @(posedge pclk);
        stim <= pats[pi];
        repeat (4) @(posedge pclk);
        for (int k = 0; k < 64; k++) begin
          c = {k[2:0], k[5:3], pi[0], 1'b1};
          apb(1, `PMUX_CTRL_ADDR, {24'h0, c}, 4'hF);
          repeat (3) @(posedge pclk);
          check(pin_o, exp_pin(c, masks[mi], pats[pi]),
                "pad level");
          check(oe_n, 1'b0, "driver off while enabled");
        end
      end
    end
  endtask

  // driver disabled releases the net, stored value held back
  task automatic t_disable();
    apb(1, `PMUX_CTRL_ADDR, 32'h0000_0012, 4'hF);
    repeat (3) @(posedge pclk);
    check({oe_n, pin_o, net_level}, 3'b100, "disabled pad");
  endtask

  // second reset in mid-run brings control back to zero
  task automatic t_rereset();
    apb(1, `PMUX_CTRL_ADDR, 32'h0000_0013, 4'hF);
    repeat (3) @(posedge pclk);
    check(net_level, 1'b1, "stored value not on net");
    // all status inputs high: lock, sync, tx frame, pad level, enable
    apb(0, `PMUX_STAT_ADDR, 0, 4'hF);
    check(rd, 32'h0000_00FF, "status register");
    check(er, 1'b0, "status read flagged");
    // the status word is read only; a write is dropped without error
    apb(1, `PMUX_STAT_ADDR, 0, 4'hF);
    check(er, 1'b0, "status write flagged");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    check(oe_n, 1'b1, "driver on in reset");
    apb(0, `PMUX_CTRL_ADDR, 0, 4'hF);
    check(rd, 32'h0000_0000, "control after reset");
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_sweep();
    t_disable();
    t_rereset();
    wrap_up();
  end
endmodule
